/* File: design/flash_cmd_dev.sv */
// Device end: takes serial frames, decodes commands and polices concurrency
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_dev
  import flash_cmd_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  flash_link_if.dev link,
  // Core busy state
  input wire logic array_busy,
  input wire logic protect_busy,
  // Byte returned on the serial output
  input wire logic [7:0] reply_byte,
  // Decoded command stream
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [7:0] cmd_op,
  output logic [7:0] cmd_fin,
  output logic [ADDR_W-1:0] cmd_addr,
  output cmd_grp_t cmd_grp,
  output logic cmd_ok,
  output logic cmd_refused,
  output logic cmd_bad,
  // Status
  output logic overrun,
  output logic power_down
);

  localparam int DESC_W = 8 + 8 + ADDR_W + 3 + 3;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // ==========================================================
  // Pin synchronisers
  logic cs_m_r, cs_s_r, cs_d_r;
  logic sck_m_r, sck_s_r, sck_d_r;
  logic si_m_r, si_s_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      si_m_r <= 1'b0;
      si_s_r <= 1'b0;
    end
    else
    begin
      cs_m_r <= link.cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      sck_m_r <= link.sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      si_m_r <= link.si;
      si_s_r <= si_m_r;
    end
  end

  // Edges seen on synchronised copies only
  wire in_frame_w = !cs_s_r;
  wire frame_start_w = cs_d_r && !cs_s_r;
  wire frame_end_w = !cs_d_r && cs_s_r;
  wire sck_rise_w = in_frame_w && !sck_d_r && sck_s_r;
  wire sck_fall_w = in_frame_w && sck_d_r && !sck_s_r;

  // ==========================================================
  // Bit capture: first four bytes, later bytes are data
  logic [31:0] cap_r;
  logic [5:0] bit_cnt_r;
  logic [2:0] bit_pos_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_r <= 32'h0;
      bit_cnt_r <= 6'h00;
      bit_pos_r <= 3'h0;
    end
    else if (frame_start_w)
    begin
      cap_r <= 32'h0;
      bit_cnt_r <= 6'h00;
      bit_pos_r <= 3'h0;
    end
    else if (sck_rise_w)
    begin
      bit_pos_r <= bit_pos_r + 3'h1;
      if (!bit_cnt_r[5])
      begin
        cap_r[~bit_cnt_r[4:0]] <= si_s_r;
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  // ==========================================================
  // Command decode at frame end
  logic dpd_r;
  cmd_grp_t grp_w;

  wire [7:0] op_w = cap_r[31:24];
  wire [15:0] mid_w = cap_r[23:8];
  wire [7:0] fin_w = cap_r[7:0];
  wire [2:0] nbytes_w = bit_cnt_r[5:3];
  wire seq_w = cmd_is_seq(op_w);
  wire [3:0] need_w = (seq_w || cmd_has_addr(op_w)) ? HDR_LONG : HDR_SHORT;
  assign grp_w = cmd_group(op_w, fin_w);
  wire mid_ok_w = !seq_w || (mid_w == seq_mid(op_w));
  wire short_w = {1'b0, nbytes_w} < need_w;
  wire bad_w = (grp_w == GRP_NONE) || short_w || !mid_ok_w;

  // Asleep only wake-up is honoured; status passes both busy checks
  wire ref_dpd_w = dpd_r && (op_w != OP_PWR_UP);
  wire ref_prot_w = protect_busy && !cmd_is_status(op_w);
  wire ref_arr_w = array_busy && (grp_w != GRP_CONCURRENT);
  wire refused_w = !bad_w && (ref_dpd_w || ref_prot_w || ref_arr_w);
  wire ok_w = !bad_w && !refused_w;
  wire [ADDR_W-1:0] addr_w = cap_r[ADDR_W-1:0] & addr_mask(op_w);
  wire [DESC_W-1:0] desc_w = {op_w, fin_w, addr_w, grp_w, ok_w, refused_w, bad_w};

  // Power-down state follows accepted commands only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dpd_r <= 1'b0;
    else if (frame_end_w && ok_w && (op_w == OP_PWR_DOWN))
      dpd_r <= 1'b1;
    else if (frame_end_w && ok_w && (op_w == OP_PWR_UP))
      dpd_r <= 1'b0;
  end

  // ==========================================================
  // Holding slot and output buffer
  logic pend_v_r;
  logic [DESC_W-1:0] pend_r;
  logic [DESC_W-1:0] q_r [DEPTH];
  logic [CNT_W-1:0] cnt_r;
  logic overrun_r;

  wire pop_w = cmd_valid && cmd_ready;
  wire room_w = (32'(cnt_r) < DEPTH) || pop_w;
  wire push_w = pend_v_r && room_w;
  wire [CNT_W-1:0] cnt_left_w = cnt_r - CNT_W'(pop_w);
  wire [CNT_W-1:0] cnt_nxt = cnt_left_w + CNT_W'(push_w);

  // A frame may end while the slot still waits; that case is flagged unless a pop frees room in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_v_r <= 1'b0;
      pend_r <= '0;
      overrun_r <= 1'b0;
    end
    else
    begin
      overrun_r <= frame_end_w && pend_v_r && !push_w;
      if (frame_end_w)
      begin
        pend_v_r <= 1'b1;
        pend_r <= desc_w;
      end
      else if (push_w)
        pend_v_r <= 1'b0;
    end
  end

  // Shift buffer keeps the head in entry zero, so outputs are flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
        q_r[i] <= '0;
      cnt_r <= '0;
      cmd_valid <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push_w && (32'(cnt_left_w) == i))
          q_r[i] <= pend_r;
        else if (pop_w && (i < DEPTH - 1))
          q_r[i] <= q_r[(i + 1) % DEPTH];
      end
      cnt_r <= cnt_nxt;
      cmd_valid <= cnt_nxt != '0;
    end
  end

  assign cmd_op = q_r[0][DESC_W-1 -: 8];
  assign cmd_fin = q_r[0][DESC_W-9 -: 8];
  assign cmd_addr = q_r[0][ADDR_W+5 : 6];
  assign cmd_grp = cmd_grp_t'(q_r[0][5:3]);
  assign cmd_ok = q_r[0][2];
  assign cmd_refused = q_r[0][1];
  assign cmd_bad = q_r[0][0];
  assign overrun = overrun_r;
  assign power_down = dpd_r;

  // ==========================================================
  // Reply shifter: changes on falling clock, after the opcode
  logic [7:0] tx_r;
  logic so_r, so_oe_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else
    begin
      so_oe_r <= in_frame_w && (bit_cnt_r >= 6'h08);
      if (sck_fall_w && (bit_cnt_r != 6'h00))
      begin
        if (bit_pos_r == 3'h0)
        begin
          so_r <= reply_byte[7];
          tx_r <= {reply_byte[6:0], 1'b0};
        end
        else
        begin
          so_r <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  assign link.so_o = so_r;
  assign link.so_oe = so_oe_r;

endmodule
`default_nettype wire

/* File: design/flash_cmd_host.sv */
// Host end: frames one command at a time and drives the serial clock
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  flash_link_if.host link,
  // Command request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_op,
  input wire logic [7:0] req_fin,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_rd_len,
  // Self-timed work in progress
  input wire logic b_busy,
  input wire logic [1:0] b_buf,
  input wire logic d_busy,
  // Answer
  output logic req_refused,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done
);

  // ==========================================================
  // Request screening
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_END = 2'b10,
    ST_GAP = 2'b11
  } host_st_t;

  host_st_t st_r;
  logic [$clog2(SCK_HALF)-1:0] div_r;
  logic [63:0] tx_r;
  logic [7:0] rx_r;
  logic [11:0] bit_cnt_r;
  logic [11:0] tot_bits_r;
  logic [6:0] hdr_bits_r;
  logic cs_r, sck_r, si_r;
  logic so_m_r, so_s_r;
  logic [63:0] hdr_w;

  // Clash checks against work the core still runs
  wire [1:0] req_buf_w = cmd_buffer(req_op);
  wire buf_clash_w = b_busy && (req_buf_w != 2'h0) && (req_buf_w == b_buf);
  wire not_c_w = b_busy && (cmd_group(req_op, req_fin) != GRP_CONCURRENT);
  wire d_clash_w = d_busy && !cmd_is_status(req_op);
  wire refuse_w = buf_clash_w || not_c_w || d_clash_w;
  wire take_w = req_valid && req_ready;
  wire [3:0] hdr_len_w = cmd_hdr_len(req_op);
  wire [8:0] bytes_w = 9'(hdr_len_w) + 9'(req_rd_len);
  wire tick_w = (st_r != ST_IDLE) && (32'(div_r) == SCK_HALF - 1);
  wire [11:0] bit_inc_w = bit_cnt_r + 12'h001;
  wire [7:0] rx_nxt = {rx_r[6:0], so_s_r};

  // Header bytes, left aligned, opcode first and MSB first
  always_comb
  begin
    hdr_w = 64'h0;
    if (cmd_is_seq(req_op))
      hdr_w[63:32] = {req_op, seq_mid(req_op), req_fin};
    else if (cmd_has_addr(req_op))
      hdr_w[63:32] = {req_op, 5'h00, req_addr};
    else
      hdr_w[63:56] = req_op;
  end

  // Serial input sampled on the host clock
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      so_m_r <= 1'b1;
      so_s_r <= 1'b1;
    end
    else
    begin
      so_m_r <= link.so;
      so_s_r <= so_m_r;
    end
  end

  // ==========================================================
  // Frame sequencer, mode 0: data set while clock low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ST_IDLE;
      div_r <= '0;
      tx_r <= 64'h0;
      rx_r <= 8'h00;
      bit_cnt_r <= 12'h000;
      tot_bits_r <= 12'h000;
      hdr_bits_r <= 7'h00;
      cs_r <= 1'b1;
      sck_r <= 1'b0;
      si_r <= 1'b0;
      req_ready <= 1'b1;
      req_refused <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      req_refused <= take_w && refuse_w;
      rd_valid <= 1'b0;
      done <= 1'b0;
      div_r <= tick_w ? '0 : div_r + 1'b1;
      case (st_r)
        ST_IDLE:
        begin
          div_r <= '0;
          if (take_w && !refuse_w)
          begin
            // One frame in flight, so a read always ends first
            st_r <= ST_RUN;
            req_ready <= 1'b0;
            cs_r <= 1'b0;
            tx_r <= {hdr_w[62:0], 1'b0};
            si_r <= hdr_w[63];
            bit_cnt_r <= 12'h000;
            tot_bits_r <= {bytes_w, 3'h0};
            hdr_bits_r <= {hdr_len_w, 3'h0};
          end
        end
        ST_RUN:
          if (tick_w && !sck_r)
            sck_r <= 1'b1;
          else if (tick_w)
          begin
            // Read data is sampled just before the falling edge
            sck_r <= 1'b0;
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_inc_w;
            si_r <= tx_r[63];
            tx_r <= {tx_r[62:0], 1'b0};
            if ((bit_inc_w[2:0] == 3'h0) && (bit_inc_w > 12'(hdr_bits_r)))
            begin
              rd_valid <= 1'b1;
              rd_data <= rx_nxt;
            end
            if (bit_inc_w == tot_bits_r)
              st_r <= ST_END;
          end
        ST_END:
          if (tick_w)
          begin
            cs_r <= 1'b1;
            si_r <= 1'b0;
            st_r <= ST_GAP;
          end
        ST_GAP:
          if (tick_w)
          begin
            st_r <= ST_IDLE;
            req_ready <= 1'b1;
            done <= 1'b1;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_r;
  assign link.sck = sck_r;
  assign link.si = si_r;

endmodule
`default_nettype wire

/* File: design/flash_cmd_pkg.sv */
// Opcodes, command groups and decode helpers shared by both link ends
`default_nettype none
package flash_cmd_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_PAGE_RD = 8'hd2;
  localparam logic [7:0] OP_CONT_RD_ALT = 8'he8;
  localparam logic [7:0] OP_CONT_RD_LF = 8'h03;
  localparam logic [7:0] OP_CONT_RD_HF = 8'h0b;
  localparam logic [7:0] OP_BUF1_RD_LF = 8'hd1;
  localparam logic [7:0] OP_BUF2_RD_LF = 8'hd3;
  localparam logic [7:0] OP_BUF1_RD = 8'hd4;
  localparam logic [7:0] OP_BUF2_RD = 8'hd6;
  localparam logic [7:0] OP_BUF1_WR = 8'h84;
  localparam logic [7:0] OP_BUF2_WR = 8'h87;
  localparam logic [7:0] OP_BUF1_PGM_ERS = 8'h83;
  localparam logic [7:0] OP_BUF2_PGM_ERS = 8'h86;
  localparam logic [7:0] OP_BUF1_PGM = 8'h88;
  localparam logic [7:0] OP_BUF2_PGM = 8'h89;
  localparam logic [7:0] OP_PAGE_ERS = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERS = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERS = 8'h7c;
  localparam logic [7:0] OP_CHIP_ERS = 8'hc7;
  localparam logic [7:0] CHIP_ERS_B2 = 8'h94;
  localparam logic [7:0] CHIP_ERS_B3 = 8'h80;
  localparam logic [7:0] CHIP_ERS_B4 = 8'h9a;
  localparam logic [7:0] OP_THRU_BUF1 = 8'h82;
  localparam logic [7:0] OP_THRU_BUF2 = 8'h85;
  localparam logic [7:0] OP_PROT_SEQ = 8'h3d;
  localparam logic [7:0] PROT_SEQ_B2 = 8'h2a;
  localparam logic [7:0] PROT_SEQ_B3 = 8'h7f;
  localparam logic [7:0] PROT_EN = 8'ha9;
  localparam logic [7:0] PROT_DIS = 8'h9a;
  localparam logic [7:0] PROT_ERS = 8'hcf;
  localparam logic [7:0] PROT_PGM = 8'hfc;
  localparam logic [7:0] PROT_LOCK = 8'h30;
  localparam logic [7:0] OP_RD_PROT = 8'h32;
  localparam logic [7:0] OP_RD_LOCK = 8'h35;
  localparam logic [7:0] OP_SEC_PGM = 8'h9b;
  localparam logic [7:0] SEC_PGM_PAD = 8'h00;
  localparam logic [7:0] OP_RD_SEC = 8'h77;
  localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
  localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
  localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
  localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
  localparam logic [7:0] OP_REWR_BUF1 = 8'h58;
  localparam logic [7:0] OP_REWR_BUF2 = 8'h59;
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_PWR_UP = 8'hab;
  localparam logic [7:0] OP_STATUS = 8'hd7;
  localparam logic [7:0] OP_ID = 8'h9f;
  localparam logic [7:0] OP_BUF1_RD_OLD = 8'h54;
  localparam logic [7:0] OP_BUF2_RD_OLD = 8'h56;
  localparam logic [7:0] OP_PAGE_RD_OLD = 8'h52;
  localparam logic [7:0] OP_CONT_RD_OLD = 8'h68;
  localparam logic [7:0] OP_STATUS_OLD = 8'h57;

  // ==========================================================
  // Address layout and timing
  localparam int ADDR_W = 19;
  localparam logic [3:0] HDR_LONG = 4'h4;
  localparam logic [3:0] HDR_SHORT = 4'h1;
  localparam logic [18:0] MASK_FULL = 19'h7ffff;
  localparam logic [18:0] MASK_BLOCK = 19'h7f800;
  localparam logic [18:0] MASK_PAGE = 19'h7ff00;
  localparam logic [18:0] MASK_SECTOR = 19'h70000;
  localparam logic [18:0] MASK_NONE = 19'h00000;
  localparam int SCK_HALF_CYC = 8;

  typedef enum logic [2:0] {
    GRP_NONE = 3'b000,
    GRP_ARRAY_RD = 3'b001,
    GRP_SELF_TIMED = 3'b010,
    GRP_CONCURRENT = 3'b011,
    GRP_PROTECT = 3'b100,
    GRP_OTHER = 3'b101
  } cmd_grp_t;

  // ==========================================================
  // Decode helpers
  function automatic cmd_grp_t cmd_group(input logic [7:0] op, input logic [7:0] fin);
    case (op)
      OP_PAGE_RD, OP_CONT_RD_ALT, OP_CONT_RD_LF, OP_CONT_RD_HF, OP_PAGE_RD_OLD,
      OP_CONT_RD_OLD, OP_RD_PROT, OP_RD_LOCK, OP_RD_SEC:
        return GRP_ARRAY_RD;
      OP_PAGE_ERS, OP_BLOCK_ERS, OP_SECTOR_ERS, OP_XFER_BUF1, OP_XFER_BUF2,
      OP_CMP_BUF1, OP_CMP_BUF2, OP_BUF1_PGM_ERS, OP_BUF2_PGM_ERS, OP_BUF1_PGM,
      OP_BUF2_PGM, OP_THRU_BUF1, OP_THRU_BUF2, OP_REWR_BUF1, OP_REWR_BUF2:
        return GRP_SELF_TIMED;
      OP_CHIP_ERS:
        return (fin == CHIP_ERS_B4) ? GRP_SELF_TIMED : GRP_NONE;
      OP_BUF1_RD_LF, OP_BUF2_RD_LF, OP_BUF1_RD, OP_BUF2_RD, OP_BUF1_RD_OLD,
      OP_BUF2_RD_OLD, OP_BUF1_WR, OP_BUF2_WR, OP_STATUS, OP_STATUS_OLD, OP_ID:
        return GRP_CONCURRENT;
      OP_PROT_SEQ:
        case (fin)
          PROT_ERS, PROT_PGM, PROT_LOCK: return GRP_PROTECT;
          PROT_EN, PROT_DIS: return GRP_OTHER;
          default: return GRP_NONE;
        endcase
      OP_SEC_PGM:
        return (fin == SEC_PGM_PAD) ? GRP_PROTECT : GRP_NONE;
      OP_PWR_DOWN, OP_PWR_UP:
        return GRP_OTHER;
      default:
        return GRP_NONE;
    endcase
  endfunction

  // Multi-byte commands carry fixed second and third bytes
  function automatic logic cmd_is_seq(input logic [7:0] op);
    return (op == OP_PROT_SEQ) || (op == OP_CHIP_ERS) || (op == OP_SEC_PGM);
  endfunction

  function automatic logic [15:0] seq_mid(input logic [7:0] op);
    case (op)
      OP_PROT_SEQ: return {PROT_SEQ_B2, PROT_SEQ_B3};
      OP_CHIP_ERS: return {CHIP_ERS_B2, CHIP_ERS_B3};
      OP_SEC_PGM: return {SEC_PGM_PAD, SEC_PGM_PAD};
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic cmd_has_addr(input logic [7:0] op);
    case (op)
      OP_ID, OP_PWR_DOWN, OP_PWR_UP, OP_STATUS, OP_STATUS_OLD,
      OP_PROT_SEQ, OP_CHIP_ERS, OP_SEC_PGM:
        return 1'b0;
      default:
        return cmd_group(op, 8'h00) != GRP_NONE;
    endcase
  endfunction

  function automatic logic [3:0] cmd_dummy(input logic [7:0] op);
    case (op)
      OP_CONT_RD_HF, OP_BUF1_RD, OP_BUF2_RD: return 4'h1;
      OP_PAGE_RD, OP_CONT_RD_ALT: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction

  // Header bytes the host shifts before any read data
  function automatic logic [3:0] cmd_hdr_len(input logic [7:0] op);
    if (cmd_is_seq(op))
      return HDR_LONG;
    if (cmd_has_addr(op))
      return HDR_LONG + cmd_dummy(op);
    return HDR_SHORT;
  endfunction

  function automatic logic [18:0] addr_mask(input logic [7:0] op);
    case (op)
      OP_BLOCK_ERS: return MASK_BLOCK;
      OP_PAGE_ERS, OP_XFER_BUF1, OP_XFER_BUF2, OP_CMP_BUF1, OP_CMP_BUF2,
      OP_REWR_BUF1, OP_REWR_BUF2: return MASK_PAGE;
      OP_SECTOR_ERS: return MASK_SECTOR;
      OP_RD_SEC: return MASK_NONE;
      default: return MASK_FULL;
    endcase
  endfunction

  // Which SRAM buffer a concurrent buffer access touches
  function automatic logic [1:0] cmd_buffer(input logic [7:0] op);
    case (op)
      OP_BUF1_RD_LF, OP_BUF1_RD, OP_BUF1_RD_OLD, OP_BUF1_WR: return 2'h1;
      OP_BUF2_RD_LF, OP_BUF2_RD, OP_BUF2_RD_OLD, OP_BUF2_WR: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic cmd_is_status(input logic [7:0] op);
    return (op == OP_STATUS) || (op == OP_STATUS_OLD);
  endfunction

endpackage
`default_nettype wire

/* File: design/flash_link_if.sv */
// Serial link between the host controller and the flash command decoder
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  // Host driven pins
  logic cs_n;
  logic sck;
  logic si;
  // Device serial output and its enable
  logic so_o;
  logic so_oe;
  logic so;

  // Released output reads high, as through a pull-up
  assign so = so_oe ? so_o : 1'b1;

  modport host (output cs_n, output sck, output si, input so);
  modport dev (input cs_n, input sck, input si, output so_o, output so_oe);
endinterface
`default_nettype wire

/* File: test/flash_link_sva.sv */
// Wire checks on the serial link joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
module flash_link_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe,
  input wire logic so
);
  // ==========================================================
  // Framing and serial clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sck_idle_a: assert property (cs_n |-> !sck) else $error("sck high outside frame");
  si_hold_a: assert property ($changed(si) |-> !sck) else $error("si moved with sck high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4]) else $error("sck high too short");
  sck_low_a: assert property ($fell(sck) && !cs_n |-> !sck [*4]) else $error("sck low too short");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4]) else $error("select gap too short");
  // Output off for 8 clocks after select, released when the frame ends
  so_opcode_a: assert property ($fell(cs_n) |-> !so_oe [*8]) else $error("so driven in opcode");
  so_release_a: assert property ($rose(cs_n) |-> ##[1:8] !so_oe) else $error("so not released");
  so_setup_a: assert property ($changed(so) && so_oe && $past(so_oe) |-> !sck)
    else $error("so moved with sck high");
  // Main scenarios
  cover property ($rose(so_oe));
  cover property ($rose(cs_n));
  cover property ($fell(sck) && !cs_n);
endmodule
`default_nettype wire

/* File: test/serial_flash_command_decoder_bench.sv */
// Bench driving host requests and checking decoded commands at the device end
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_decoder_bench import flash_cmd_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, b_busy = 1'b0, d_busy = 1'b0;
  logic array_busy = 1'b0, protect_busy = 1'b0, cmd_ready = 1'b0;
  logic [7:0] req_op = 8'h00, req_fin = 8'h00, req_rd_len = 8'h00, reply_byte = 8'h1e;
  logic [1:0] b_buf = 2'h0;
  logic [ADDR_W-1:0] req_addr = 19'h00000;
  logic req_ready, req_refused, rd_valid, done, cmd_valid, cmd_ok, cmd_refused, cmd_bad;
  logic overrun, power_down, ovr_seen = 1'b0;
  logic [7:0] rd_data, cmd_op, cmd_fin, rd_seen = 8'h00;
  logic [ADDR_W-1:0] cmd_addr;
  cmd_grp_t cmd_grp;
  int fails = 0, checked = 0, cycles = 0;
  localparam logic [18:0] ADR = 19'h5b6c7;

  // ==========================================================
  // Link and both ends
  flash_link_if u_flash_link_if ();
  flash_cmd_host u_flash_cmd_host (.clk(clk), .nrst(nrst), .link(u_flash_link_if.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_fin(req_fin),
    .req_addr(req_addr), .req_rd_len(req_rd_len), .b_busy(b_busy), .b_buf(b_buf),
    .d_busy(d_busy), .req_refused(req_refused), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done));
  flash_cmd_dev u_flash_cmd_dev (.clk(clk), .nrst(nrst), .link(u_flash_link_if.dev),
    .array_busy(array_busy), .protect_busy(protect_busy), .reply_byte(reply_byte),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_fin(cmd_fin),
    .cmd_addr(cmd_addr), .cmd_grp(cmd_grp), .cmd_ok(cmd_ok), .cmd_refused(cmd_refused),
    .cmd_bad(cmd_bad), .overrun(overrun), .power_down(power_down));
  flash_link_sva u_flash_link_sva (.clk(clk), .nrst(nrst), .cs_n(u_flash_link_if.cs_n),
    .sck(u_flash_link_if.sck), .si(u_flash_link_if.si), .so_oe(u_flash_link_if.so_oe),
    .so(u_flash_link_if.so));

  // ==========================================================
  // Clock, watchdog and sticky observers
  initial forever #2.5 clk = ~clk;
  // Pulses are caught here so a task waiting elsewhere cannot miss them
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rd_valid === 1'b1) rd_seen <= rd_data;
    if (overrun === 1'b1) ovr_seen <= 1'b1;
    if (cycles == 90000)
    begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Request held until taken, then wait for frame end or refusal
  task automatic send(input logic [7:0] op, fin, input logic [18:0] a, input logic ref_exp);
    req_op <= op;
    req_fin <= fin;
    req_addr <= a;
    req_valid <= 1'b1;
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    do @(posedge clk); while (done !== 1'b1 && req_refused !== 1'b1);
    chk("host refused", ref_exp, req_refused);
  endtask
  // Ready only pulsed here, so a descriptor waits for its check
  task automatic get(input logic [7:0] op, ef, input cmd_grp_t g, input logic [18:0] ea,
    input logic ca, input logic [2:0] f);
    while (cmd_valid !== 1'b1) @(posedge clk);
    chk("cmd_op", op, cmd_op);
    chk("cmd_fin", ef, cmd_fin);
    chk("cmd_grp", g, cmd_grp);
    chk("ok refused bad", f, {cmd_ok, cmd_refused, cmd_bad});
    if (ca) chk("cmd_addr", ea, cmd_addr);
    cmd_ready <= 1'b1;
    @(posedge clk);
    cmd_ready <= 1'b0;
    // Let the pop settle so the next look sees the new head
    @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, fin, input logic [18:0] a, input cmd_grp_t g,
    input logic [18:0] ea, input logic ca, input logic [2:0] f);
    send(op, fin, a, 1'b0);
    get(op, fin | a[7:0], g, ea, ca, f);
  endtask
  task automatic run(input logic [7:0] ops[$], input cmd_grp_t g);
    foreach (ops[i]) cmd(ops[i], 8'h00, 19'h00000, g, 19'h00000, 1'b0, 3'b100);
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run('{8'hd2, 8'he8, 8'h03, 8'h0b, 8'h32, 8'h35, 8'h77}, GRP_ARRAY_RD);
    run('{8'h52, 8'h68}, GRP_ARRAY_RD);
    run('{8'h81, 8'h50, 8'h7c, 8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85}, GRP_SELF_TIMED);
    run('{8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59}, GRP_SELF_TIMED);
    run('{8'hd1, 8'hd3, 8'hd4, 8'hd6, 8'h84, 8'h87, 8'hd7, 8'h9f}, GRP_CONCURRENT);
    run('{8'h54, 8'h56, 8'h57}, GRP_CONCURRENT);
    cmd(8'hc7, 8'h9a, 0, GRP_SELF_TIMED, 0, 1'b0, 3'b100);
    cmd(8'hc7, 8'h00, 0, GRP_NONE, 0, 1'b0, 3'b001);
    cmd(8'h3d, 8'hcf, 0, GRP_PROTECT, 0, 1'b0, 3'b100);
    cmd(8'h3d, 8'hfc, 0, GRP_PROTECT, 0, 1'b0, 3'b100);
    cmd(8'h3d, 8'h30, 0, GRP_PROTECT, 0, 1'b0, 3'b100);
    cmd(8'h3d, 8'ha9, 0, GRP_OTHER, 0, 1'b0, 3'b100);
    cmd(8'h3d, 8'h9a, 0, GRP_OTHER, 0, 1'b0, 3'b100);
    cmd(8'h3d, 8'h11, 0, GRP_NONE, 0, 1'b0, 3'b001);
    cmd(8'h9b, 8'h00, 0, GRP_PROTECT, 0, 1'b0, 3'b100);
    // Address layout, most significant bit first, per-command masks
    cmd(8'h03, 0, ADR, GRP_ARRAY_RD, ADR & MASK_FULL, 1'b1, 3'b100);
    cmd(8'h0b, 0, ADR, GRP_ARRAY_RD, ADR & MASK_FULL, 1'b1, 3'b100);
    cmd(8'h50, 0, ADR, GRP_SELF_TIMED, ADR & MASK_BLOCK, 1'b1, 3'b100);
    cmd(8'h53, 0, ADR, GRP_SELF_TIMED, ADR & MASK_PAGE, 1'b1, 3'b100);
    cmd(8'h7c, 0, ADR, GRP_SELF_TIMED, ADR & MASK_SECTOR, 1'b1, 3'b100);
    cmd(8'h77, 0, ADR, GRP_ARRAY_RD, MASK_NONE, 1'b1, 3'b100);
    // Busy device: array busy lets concurrent commands run, protect busy only status
    array_busy <= 1'b1;
    cmd(8'h81, 0, 0, GRP_SELF_TIMED, 0, 1'b0, 3'b010);
    cmd(8'hd4, 0, 0, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    array_busy <= 1'b0;
    protect_busy <= 1'b1;
    req_rd_len <= 8'h01;
    cmd(8'h84, 0, 0, GRP_CONCURRENT, 0, 1'b0, 3'b010);
    chk("rd_data", 8'h1e, rd_seen);
    // A fresh reply value proves the status frame itself read a byte
    reply_byte <= 8'h5a;
    cmd(8'hd7, 0, 0, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    chk("rd_data", 8'h5a, rd_seen);
    protect_busy <= 1'b0;
    req_rd_len <= 8'h00;
    // Host screening while self-timed work uses buffer one, then while d_busy is set
    b_busy <= 1'b1;
    b_buf <= 2'h1;
    send(8'h84, 0, 0, 1'b1);
    send(8'h81, 0, 0, 1'b1);
    cmd(8'h87, 0, 0, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    b_busy <= 1'b0;
    d_busy <= 1'b1;
    send(8'hd4, 0, 0, 1'b1);
    cmd(8'hd7, 0, 0, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    d_busy <= 1'b0;
    // Deep power-down refuses all but resume
    cmd(8'hb9, 0, 0, GRP_OTHER, 0, 1'b0, 3'b100);
    chk("power_down", 1'b1, power_down);
    cmd(8'h53, 0, 0, GRP_SELF_TIMED, 0, 1'b0, 3'b010);
    cmd(8'hab, 0, 0, GRP_OTHER, 0, 1'b0, 3'b100);
    chk("power_down", 1'b0, power_down);
    // Stalled receiver: two queued, third held, fourth replaces it
    chk("overrun", 1'b0, ovr_seen);
    send(8'hd7, 0, 0, 1'b0);
    send(8'h57, 0, 0, 1'b0);
    send(8'h9f, 0, 0, 1'b0);
    send(8'hd4, 0, 0, 1'b0);
    repeat (10) @(posedge clk);
    chk("overrun", 1'b1, ovr_seen);
    get(8'hd7, 8'h00, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    get(8'h57, 8'h00, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    get(8'hd4, 8'h00, GRP_CONCURRENT, 0, 1'b0, 3'b100);
    test_done();
  end
endmodule
`default_nettype wire
